/* File: core/tfu_pkg.sv */
// Constants, register map and carrier types for the timer unit
package tfu_pkg;

  // Timer tick reference rate and bus clock rate
  localparam int TFU_TICK_HZ     = 13_560_000;
  localparam int TFU_PCLK_HZ     = 10_000_000;

  // Widths of the two stages and the bus, and the number of flags
  localparam int TFU_PRE_W       = 12;
  localparam int TFU_PRE_STAGE_W = 13;
  localparam int TFU_CNT_W       = 16;
  localparam int TFU_AW          = 8;
  localparam int TFU_DW          = 32;
  localparam int TFU_IRQ_N       = 2;

  // Byte offsets of the registers
  localparam logic [7:0] TFU_OFF_MODE    = 8'h00;
  localparam logic [7:0] TFU_OFF_PRE_LO  = 8'h04;
  localparam logic [7:0] TFU_OFF_RELOAD  = 8'h08;
  localparam logic [7:0] TFU_OFF_COUNT   = 8'h0C;
  localparam logic [7:0] TFU_OFF_CTRL    = 8'h10;
  localparam logic [7:0] TFU_OFF_STATUS  = 8'h14;
  localparam logic [7:0] TFU_OFF_IRQ_ST  = 8'h18;
  localparam logic [7:0] TFU_OFF_IRQ_CLR = 8'h1C;
  localparam logic [7:0] TFU_OFF_IRQ_EN  = 8'h20;
  localparam logic [7:0] TFU_OFF_IRQ_SET = 8'h24;

  // Field positions
  localparam int TFU_MODE_AUTO     = 7;
  localparam int TFU_MODE_PERIODIC = 6;
  localparam int TFU_MODE_EVEN     = 5;
  localparam int TFU_MODE_PHI_LSB  = 0;
  localparam int TFU_CTRL_START    = 0;
  localparam int TFU_CTRL_STOP     = 1;
  localparam int TFU_STAT_RUN      = 0;
  localparam int TFU_IRQ_EXPIRED   = 0;
  localparam int TFU_IRQ_STARTED   = 1;

  // Values after reset
  localparam logic [7:0]  TFU_MODE_RST   = 8'h00;
  localparam logic [7:0]  TFU_PRE_LO_RST = 8'h00;
  localparam logic [15:0] TFU_RELOAD_RST = 16'h0000;
  localparam logic [1:0]  TFU_IRQ_EN_RST = 2'h0;

  typedef struct packed {
    logic       auto_go;
    logic       periodic;
    logic       even;
    logic [3:0] presc_hi;
  } tfu_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tfu_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tfu_apb_rsp_t;

endpackage

/* File: core/tfu_stage.sv */
// One reloadable down-counting stage of the timer
`timescale 1ns/1ps
`default_nettype none
module tfu_stage #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic         tick,
  input  wire logic [W-1:0] reload,
  output logic      [W-1:0] value,
  output logic              hit_one,
  output logic              wrap
);

  // Counts reload..0, so one period is reload+1 ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= '0;
    end else if (load) begin
      value <= reload;
    end else if (tick) begin
      if (value == '0) begin
        value <= reload;
      end else begin
        value <= value - W'(1);
      end
    end
  end

  assign hit_one = tick && (value == W'(1));
  assign wrap    = tick && (value == '0);

endmodule
`default_nettype wire

/* File: core/tfu_irq.sv */
// Sticky event flags with enable mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module tfu_irq #(
  parameter int N = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] event_set,
  input  wire logic [N-1:0] sw_set,
  input  wire logic [N-1:0] sw_clear,
  input  wire logic [N-1:0] enable,
  output logic      [N-1:0] status,
  output logic              irq
);

  // Set beats clear so an event in the clear cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~sw_clear) | sw_set | event_set;
    end
  end

  assign irq = |(status & enable);

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
      (|(event_set & enable)) |=> irq || $changed(enable);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq missed an enabled event");

  property p_set_wins;
    @(posedge clk) disable iff (!rst_n)
      (event_set[0] && sw_clear[0]) |=> status[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost against a clear");

endmodule
`default_nettype wire

/* File: core/tfu_timer.sv */
// Timer unit top: APB registers, prescaler and counter, interrupts
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Two cascaded stages on the bus clock
// - 12-bit prescaler reload across two registers
// - 16-bit counter reload in its own register
// - Counter value readable, read only
// - Zero sets flag; enabled flag drives interrupt
// - Host can set and clear the flag
// - At zero halt or reload per mode
// - Status bit shows timer running
// - Control bits start or stop immediately
// - Auto mode starts on protocol event
// - Each stage delays reload plus one ticks
// - Prescale period 2P+1, or 2P+2 when even
// - Expiry only touches flags and run state
// - Flag rises on count one to zero
module tfu_timer (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire tfu_pkg::tfu_apb_req_t apb_req,
  output var  tfu_pkg::tfu_apb_rsp_t apb_rsp,
  input  wire logic                  tx_end_event,
  output logic                       timer_active_status,
  output logic                       irq
);

  import tfu_pkg::*;

  tfu_mode_t                   timer_mode_register;
  logic [7:0]                  prescale_low_register;
  logic [TFU_CNT_W-1:0]        count_reload_register;
  logic [TFU_IRQ_N-1:0]        irq_enable;
  logic [TFU_IRQ_N-1:0]        shared_interrupt_flags;
  logic [TFU_PRE_W-1:0]        prescale_reload;
  logic [TFU_PRE_STAGE_W-1:0]  pre_stage_reload;
  logic [TFU_PRE_STAGE_W-1:0]  pre_value;
  logic [TFU_CNT_W-1:0]        count_value_register;
  logic                        pre_wrap;
  logic                        pre_hit_one;
  logic                        cnt_hit_one;
  logic                        cnt_wrap;
  logic                        running;
  logic                        access;
  logic                        wr;
  logic                        addr_ok;
  logic                        start_timer_now;
  logic                        halt_timer_now;
  logic                        auto_fire;
  logic                        go;
  logic                        expire;
  logic [TFU_IRQ_N-1:0]        ev_set;
  logic [TFU_IRQ_N-1:0]        sw_set;
  logic [TFU_IRQ_N-1:0]        sw_clr;
  logic [31:0]                 next_rdata;
  logic [31:0]                 rdata;
  logic                        ready;
  logic                        slverr;

  // APB: one wait state, so read data and ready come from flops
  assign access = apb_req.psel && apb_req.penable;
  assign wr     = access && ready && apb_req.pwrite;

  always_comb begin
    addr_ok = 1'b1;
    if (apb_req.paddr == TFU_OFF_MODE) begin
      next_rdata = {24'h000000, timer_mode_register.auto_go,
                    timer_mode_register.periodic,
                    timer_mode_register.even, 1'b0,
                    timer_mode_register.presc_hi};
    end else if (apb_req.paddr == TFU_OFF_PRE_LO) begin
      next_rdata = {24'h000000, prescale_low_register};
    end else if (apb_req.paddr == TFU_OFF_RELOAD) begin
      next_rdata = {16'h0000, count_reload_register};
    end else if (apb_req.paddr == TFU_OFF_COUNT) begin
      next_rdata = {16'h0000, count_value_register};
    end else if (apb_req.paddr == TFU_OFF_CTRL) begin
      next_rdata = 32'h00000000;
    end else if (apb_req.paddr == TFU_OFF_STATUS) begin
      next_rdata = {31'h0, running};
    end else if (apb_req.paddr == TFU_OFF_IRQ_ST) begin
      next_rdata = {30'h0, shared_interrupt_flags};
    end else if (apb_req.paddr == TFU_OFF_IRQ_CLR) begin
      next_rdata = 32'h00000000;
    end else if (apb_req.paddr == TFU_OFF_IRQ_EN) begin
      next_rdata = {30'h0, irq_enable};
    end else if (apb_req.paddr == TFU_OFF_IRQ_SET) begin
      next_rdata = 32'h00000000;
    end else begin
      next_rdata = 32'h00000000;
      addr_ok    = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready  <= 1'b0;
      rdata  <= 32'h00000000;
      slverr <= 1'b0;
    end else begin
      ready  <= access && !ready;
      slverr <= access && !ready && !addr_ok;
      if (access && !ready && !apb_req.pwrite) begin
        rdata <= next_rdata;
      end
    end
  end

  assign apb_rsp.prdata  = rdata;
  assign apb_rsp.pready  = ready;
  assign apb_rsp.pslverr = slverr;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_register   <= tfu_mode_t'({TFU_MODE_RST[7:5],
                                            TFU_MODE_RST[3:0]});
      prescale_low_register <= TFU_PRE_LO_RST;
      count_reload_register <= TFU_RELOAD_RST;
      irq_enable            <= TFU_IRQ_EN_RST;
    end else if (wr) begin
      if (apb_req.paddr == TFU_OFF_MODE) begin
        timer_mode_register.auto_go  <= apb_req.pwdata[TFU_MODE_AUTO];
        timer_mode_register.periodic <= apb_req.pwdata[TFU_MODE_PERIODIC];
        timer_mode_register.even     <= apb_req.pwdata[TFU_MODE_EVEN];
        timer_mode_register.presc_hi <=
          apb_req.pwdata[TFU_MODE_PHI_LSB +: 4];
      end else if (apb_req.paddr == TFU_OFF_PRE_LO) begin
        prescale_low_register <= apb_req.pwdata[7:0];
      end else if (apb_req.paddr == TFU_OFF_RELOAD) begin
        count_reload_register <= apb_req.pwdata[15:0];
      end else if (apb_req.paddr == TFU_OFF_IRQ_EN) begin
        irq_enable <= apb_req.pwdata[TFU_IRQ_N-1:0];
      end
    end
  end

  // Control strobes; stop beats start in the same write
  assign start_timer_now = wr && (apb_req.paddr == TFU_OFF_CTRL)
                           && apb_req.pwdata[TFU_CTRL_START];
  assign halt_timer_now  = wr && (apb_req.paddr == TFU_OFF_CTRL)
                           && apb_req.pwdata[TFU_CTRL_STOP];
  assign auto_fire = timer_mode_register.auto_go && tx_end_event;
  assign go        = (start_timer_now || auto_fire) && !halt_timer_now;

  // Prescaler reload: 2P gives 2P+1 clocks, 2P+1 gives 2P+2
  assign prescale_reload  = {timer_mode_register.presc_hi,
                             prescale_low_register};
  assign pre_stage_reload = {prescale_reload,
                             timer_mode_register.even};

  // Run state; a start reloads both stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
    end else if (halt_timer_now) begin
      running <= 1'b0;
    end else if (go) begin
      running <= 1'b1;
    end else if (expire && !timer_mode_register.periodic) begin
      running <= 1'b0;
    end
  end

  assign timer_active_status = running;

  // Prescaler ticks on every clock while running
  tfu_stage #(.W(TFU_PRE_STAGE_W)) u_pre (
    .clk     (pclk),
    .rst_n   (presetn),
    .load    (go),
    .tick    (running),
    .reload  (pre_stage_reload),
    .value   (pre_value),
    .hit_one (pre_hit_one),
    .wrap    (pre_wrap)
  );

  // Counter ticks once per prescaler underflow
  tfu_stage #(.W(TFU_CNT_W)) u_cnt (
    .clk     (pclk),
    .rst_n   (presetn),
    .load    (go),
    .tick    (pre_wrap),
    .reload  (count_reload_register),
    .value   (count_value_register),
    .hit_one (cnt_hit_one),
    .wrap    (cnt_wrap)
  );

  // Expiry feeds the flags and the run state only
  assign expire = cnt_hit_one && running;
  assign ev_set = {go, expire};
  assign sw_set = (wr && apb_req.paddr == TFU_OFF_IRQ_SET)
                  ? apb_req.pwdata[TFU_IRQ_N-1:0] : '0;
  assign sw_clr = (wr && apb_req.paddr == TFU_OFF_IRQ_CLR)
                  ? apb_req.pwdata[TFU_IRQ_N-1:0] : '0;

  tfu_irq #(.N(TFU_IRQ_N)) u_irq (
    .clk       (pclk),
    .rst_n     (presetn),
    .event_set (ev_set),
    .sw_set    (sw_set),
    .sw_clear  (sw_clr),
    .enable    (irq_enable),
    .status    (shared_interrupt_flags),
    .irq       (irq)
  );

  // Checks

  sequence s_start;
    go && !halt_timer_now;
  endsequence

  sequence s_runs_two;
    running [*2];
  endsequence

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      s_start |=> s_runs_two or (running ##1 !running);
  endproperty
  a_start: assert property (p_start)
    else $error("start did not set running");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      halt_timer_now |=> !running;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not clear running");

  property p_flag;
    @(posedge pclk) disable iff (!presetn)
      (running && pre_wrap && count_value_register == 16'h0001)
        |=> shared_interrupt_flags[TFU_IRQ_EXPIRED]
            && count_value_register == 16'h0000;
  endproperty
  a_flag: assert property (p_flag)
    else $error("expiry flag not raised on one to zero");

  property p_oneshot;
    @(posedge pclk) disable iff (!presetn)
      (expire && !timer_mode_register.periodic && !go)
        |=> !running ##1 $stable(count_value_register);
  endproperty
  a_oneshot: assert property (p_oneshot)
    else $error("one-shot timer kept running");

  property p_periodic;
    @(posedge pclk) disable iff (!presetn)
      (expire && timer_mode_register.periodic && !halt_timer_now)
        |=> running;
  endproperty
  a_periodic: assert property (p_periodic)
    else $error("periodic timer stopped at zero");

  property p_auto;
    @(posedge pclk) disable iff (!presetn)
      (tx_end_event && timer_mode_register.auto_go && !halt_timer_now)
        |=> running && count_value_register == $past(count_reload_register);
  endproperty
  a_auto: assert property (p_auto)
    else $error("auto start did not load and run");

  property p_decrement;
    @(posedge pclk) disable iff (!presetn)
      (running && pre_wrap && !go && count_value_register != 16'h0000)
        |=> count_value_register == $past(count_value_register) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step on prescaler underflow");

  property p_prescale;
    @(posedge pclk) disable iff (!presetn)
      (running && !go && pre_value == 13'h0000 && !halt_timer_now)
        |=> pre_value == pre_stage_reload;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler did not reload from 2P or 2P+1");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (!running && !go) |=> $stable(count_value_register);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter moved while stopped");

  // Bus answers after exactly one wait state, for one cycle
  sequence s_access_first;
    access && !ready;
  endsequence

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
      s_access_first |=> ready;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("bus answer not after one wait state");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      ready |=> !ready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("bus ready held for more than one cycle");

  property p_host_set;
    @(posedge pclk) disable iff (!presetn)
      sw_set[TFU_IRQ_EXPIRED] |=> shared_interrupt_flags[TFU_IRQ_EXPIRED];
  endproperty
  a_host_set: assert property (p_host_set)
    else $error("host set did not raise the expiry flag");

  property p_host_clear;
    @(posedge pclk) disable iff (!presetn)
      (sw_clr[TFU_IRQ_EXPIRED] && !sw_set[TFU_IRQ_EXPIRED] && !expire)
        |=> !shared_interrupt_flags[TFU_IRQ_EXPIRED];
  endproperty
  a_host_clear: assert property (p_host_clear)
    else $error("host clear did not drop the expiry flag");

  property p_expiry_contained;
    @(posedge pclk) disable iff (!presetn)
      (expire && !wr) |=> $stable(count_reload_register)
        && $stable(prescale_reload) && $stable(irq_enable);
  endproperty
  a_expiry_contained: assert property (p_expiry_contained)
    else $error("expiry disturbed the configuration");

  // Period check helpers; reload latched as the prescaler took it
  logic [TFU_PRE_STAGE_W-1:0]  since_wrap;
  logic [TFU_PRE_STAGE_W-1:0]  pre_loaded;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wrap <= '0;
    end else if (go || pre_wrap || !running) begin
      since_wrap <= '0;
    end else begin
      since_wrap <= since_wrap + TFU_PRE_STAGE_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_loaded <= '0;
    end else if (go || pre_wrap) begin
      pre_loaded <= pre_stage_reload;
    end
  end

  property p_pre_period;
    @(posedge pclk) disable iff (!presetn)
      (pre_wrap && !go) |-> since_wrap == pre_loaded;
  endproperty
  a_pre_period: assert property (p_pre_period)
    else $error("prescaler period is not reload plus one");

endmodule
`default_nettype wire

/* File: sim/tfu_timer_tb.sv */
// Self-checking testbench for the timer unit
`timescale 1ns/1ps
`default_nettype none
module tfu_timer_tb;
  import tfu_pkg::*;
  logic         pclk;
  logic         presetn;
  tfu_apb_req_t req;
  tfu_apb_rsp_t rsp;
  logic         tx_end_event;
  logic         timer_active_status;
  logic         irq;
  int           miscompares;
  int           n_tests;
  logic [31:0]  rdv;
  logic         err;

  tfu_timer u_tfu_timer (
    .pclk                (pclk),
    .presetn             (presetn),
    .apb_req             (req),
    .apb_rsp             (rsp),
    .tx_end_event        (tx_end_event),
    .timer_active_status (timer_active_status),
    .irq                 (irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Starts one edge after entry so back-to-back calls never clash
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge pclk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 20) begin
      miscompares++;
      print_verdict();
    end
    rdv = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wait_irq(output time t);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge pclk);
      if (irq === 1'b1) begin
        t = $time;
        return;
      end
    end
    miscompares++;
    print_verdict();
  endtask

  task automatic setup(input logic [7:0] md, input int p, input int r);
    apb(1'b1, TFU_OFF_CTRL, 32'h2);
    apb(1'b1, TFU_OFF_MODE, {24'h0, md | {4'h0, 4'(p >> 8)}});
    apb(1'b1, TFU_OFF_PRE_LO, 32'(p & 255));
    apb(1'b1, TFU_OFF_RELOAD, 32'(r));
    apb(1'b1, TFU_OFF_IRQ_EN, 32'h1);
    apb(1'b1, TFU_OFF_IRQ_CLR, 32'h3);
  endtask

  task automatic t_regs();
    logic [7:0] offs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10,
                              8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};
    foreach (offs[i]) begin
      apb(1'b0, offs[i], 32'h0);
      check("reset value", rdv, 32'h0);
    end
    apb(1'b0, 8'h28, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, TFU_OFF_MODE, 32'hEF);
    apb(1'b0, TFU_OFF_MODE, 32'h0);
    check("mode", rdv, 32'hEF);
    apb(1'b1, TFU_OFF_PRE_LO, 32'h1A5);
    apb(1'b0, TFU_OFF_PRE_LO, 32'h0);
    check("prescale low", rdv, 32'hA5);
    apb(1'b1, TFU_OFF_RELOAD, 32'h1ABCD);
    apb(1'b0, TFU_OFF_RELOAD, 32'h0);
    check("reload", rdv, 32'hABCD);
    apb(1'b1, TFU_OFF_COUNT, 32'h55);
    apb(1'b0, TFU_OFF_COUNT, 32'h0);
    check("count read only", rdv, 32'h0);
    apb(1'b1, TFU_OFF_MODE, 32'h0);
  endtask

  task automatic t_oneshot(input int p, input logic ev, input int r);
    time t0;
    time t1;
    setup({2'b00, ev, 5'h0}, p, r);
    apb(1'b1, TFU_OFF_CTRL, 32'h1);
    t0 = $time;
    wait_irq(t1);
    check("expiry cycles", 32'((t1 - t0) / 100),
          32'(r * (2 * p + 1 + ev) + 1));
    apb(1'b0, TFU_OFF_STATUS, 32'h0);
    check("halted", rdv, 32'h0);
    apb(1'b0, TFU_OFF_COUNT, 32'h0);
    check("count at zero", rdv, 32'h0);
    apb(1'b0, TFU_OFF_IRQ_ST, 32'h0);
    check("expired flag", rdv & 32'h1, 32'h1);
  endtask

  task automatic t_periodic();
    time t1;
    time t2;
    logic [31:0] a;
    setup(8'h40, 1, 3);
    apb(1'b1, TFU_OFF_CTRL, 32'h1);
    wait_irq(t1);
    apb(1'b1, TFU_OFF_IRQ_CLR, 32'h1);
    wait_irq(t2);
    check("period", 32'((t2 - t1) / 100), 32'(4 * 3));
    apb(1'b1, TFU_OFF_CTRL, 32'h2);
    apb(1'b0, TFU_OFF_COUNT, 32'h0);
    a = rdv;
    repeat (7) @(posedge pclk);
    apb(1'b0, TFU_OFF_COUNT, 32'h0);
    check("frozen count", rdv, a);
    check("stopped", {31'h0, timer_active_status}, 32'h0);
  endtask

  task automatic t_ctrl();
    setup(8'h00, 1, 100);
    apb(1'b1, TFU_OFF_CTRL, 32'h1);
    apb(1'b0, TFU_OFF_STATUS, 32'h0);
    check("running bit", rdv, 32'h1);
    check("running pin", {31'h0, timer_active_status}, 32'h1);
    repeat (150) @(posedge pclk);
    apb(1'b1, TFU_OFF_CTRL, 32'h1);
    apb(1'b0, TFU_OFF_COUNT, 32'h0);
    check("restarted", {31'h0, rdv > 32'd97}, 32'h1);
    apb(1'b1, TFU_OFF_CTRL, 32'h3);
    apb(1'b0, TFU_OFF_STATUS, 32'h0);
    check("stop wins", rdv, 32'h0);
  endtask

  task automatic t_irq();
    apb(1'b1, TFU_OFF_IRQ_EN, 32'h0);
    apb(1'b1, TFU_OFF_IRQ_CLR, 32'h3);
    apb(1'b1, TFU_OFF_IRQ_SET, 32'h1);
    apb(1'b0, TFU_OFF_IRQ_ST, 32'h0);
    check("host set", rdv, 32'h1);
    check("masked irq", {31'h0, irq}, 32'h0);
    apb(1'b1, TFU_OFF_IRQ_EN, 32'h1);
    @(posedge pclk);
    check("enabled irq", {31'h0, irq}, 32'h1);
    apb(1'b1, TFU_OFF_IRQ_CLR, 32'h1);
    apb(1'b0, TFU_OFF_IRQ_ST, 32'h0);
    check("host clear", rdv, 32'h0);
    check("irq dropped", {31'h0, irq}, 32'h0);
  endtask

  // Pulse with auto start off first: the timer must stay idle
  task automatic t_auto();
    for (int m = 0; m < 2; m++) begin
      setup(m ? 8'h80 : 8'h00, 1, 50);
      @(posedge pclk);
      tx_end_event <= 1'b1;
      @(posedge pclk);
      tx_end_event <= 1'b0;
      repeat (3) @(posedge pclk);
      check("auto start", {31'h0, timer_active_status}, 32'(m));
    end
    apb(1'b0, TFU_OFF_IRQ_ST, 32'h0);
    check("started flag", rdv & 32'h2, 32'h2);
    apb(1'b1, TFU_OFF_CTRL, 32'h2);
  endtask

  initial begin
    miscompares  = 0;
    n_tests      = 0;
    presetn      = 1'b0;
    req          = '0;
    tx_end_event = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_oneshot(0, 1'b0, 2);
    t_oneshot(1, 1'b0, 3);
    t_oneshot(257, 1'b1, 1);
    t_periodic();
    t_ctrl();
    t_irq();
    t_auto();
    print_verdict();
  end
endmodule
`default_nettype wire
